// >>> logic/edge_sync.v
// Purpose: Two-stage synchroniser with rising edge detection
// Assumes: d comes from outside the ref_clk domain
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input wire ref_clk,
    input wire reset,
    input wire d,
    output wire level,
    output wire rise
);
    reg meta_q;
    reg sync_q;
    reg last_q;
    always @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign level = sync_q;
    assign rise = sync_q & ~last_q;
endmodule // edge_sync
`default_nettype wire

// >>> logic/flash_cmd_defs.vh
// Purpose: Shared constants for the flash command interpreter
// Assumes: 20 MHz ref_clk; byte-wide decoded frames from the link layer
// Notes: Definitions only
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH

`define ST_ACK 8'h06
`define ST_PARAM_ERR 8'h05
`define ST_CSUM_ERR 8'h07
`define ST_PROTECT_ERR 8'h10
`define ST_NACK 8'h15
`define ST_FAULT_A 8'h1A
`define ST_FAULT_B 8'h1B
`define ST_WRITE_ERR 8'h1C
`define ST_BUSY 8'hFF

`define CMD_STATUS 8'h70
`define CMD_CHIP_ERASE 8'h20
`define CMD_BLOCK_ERASE 8'h22
`define CMD_PROGRAM 8'h40

`define LEN_SHORT 8'h01
`define LEN_RANGE 8'h07
`define BLOCK_BITS 10
`define MAX_DATA_LEN 9'h100

`endif

// >>> logic/flash_cmd_engine.v
// Purpose: Target-side handling of chip erase, block erase and programming commands
// Assumes: A link layer delivers parsed frames; the serial clock arrives as link_sck
// Notes: Flash array and security are modelled by inputs and a timer
//
// Function
// [R1] Programmer waits the command gap after the previous frame before commands.
// [R2] Chip erase: send command, wait chip-erase interval, then fetch status.
// [R3] Block erase: send range command, wait block-erase interval, fetch status.
// [R4] Block erase range is start and end block 0 to 255 as bytes.
// [R5] Successful erase returns acknowledge 06H.
// [R6] Block erase 06H means every block in range was erased.
// [R7] Bad command checksum returns 07H.
// [R8] Malformed frame, wrong length or missing end byte, returns 15H.
// [R9] Non-status command during chip erase returns 15H.
// [R10] Chip erase forbidden by security returns 10H; code refuses only with prot_chip_erase and prot_boot both set.
// [R11] Block erase forbidden or touching protected boot area returns 10H.
// [R12] Block erase address off a block boundary returns 05H.
// [R13] Erase failure gives 1AH; chip erase may also give 1BH, 1CH.
// [R14] Programmer ends with timeout if no status arrives in time.
// [R15] Programmer proceeds to data only after programming command completes normally.
// [R16] Programmer waits data-frame gap before each user-data frame.
// [R17] After each data frame programmer waits, then fetches two status bytes.
// [R18] Programmer aborts on bad first byte, write-fails on bad second.
// [R19] Programmer loops to next data frame while both bytes acknowledge.
// [R20] Programmer waits final status up to verify interval times block count.
// [R21] Target verifies after writing; final status acknowledges only on success.
// [R22] Programmer splits data into frames of at most 256 bytes.
// [R23] Programming addresses must align to 1 KB blocks, else 05H.
// [R24] Internal verify failure is reported finally as 1BH.
// [R25] Programmer repeats status requests while busy until final code or timeout.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"
module flash_cmd_engine (
    input wire ref_clk,
    input wire reset,
    input wire link_sck,
    input wire frame_valid,
    input wire frame_is_data,
    input wire [7:0] frame_cmd,
    input wire [7:0] frame_length_field,
    input wire [23:0] start_addr_bytes,
    input wire [23:0] end_addr_bytes,
    input wire [8:0] data_count,
    input wire data_end,
    input wire csum_ok,
    input wire etx_ok,
    input wire prot_write,
    input wire prot_block_erase,
    input wire prot_chip_erase,
    input wire prot_boot,
    input wire [23:0] boot_end_addr,
    input wire internal_fault_a,
    input wire internal_fault_b,
    input wire write_fault,
    input wire verify_fault,
    input wire [23:0] erase_cycles,
    input wire [23:0] write_cycles,
    output reg [7:0] first_status_byte,
    output reg [7:0] second_status_byte,
    output reg status_update,
    output wire flash_busy,
    output reg [7:0] sck_edges
);
    // One-hot states; the timer runs in erase, write and verify
    localparam S_IDLE = 5'b00001;
    localparam S_ERASE = 5'b00010;
    localparam S_DATA = 5'b00100;
    localparam S_WRITE = 5'b01000;
    localparam S_VERIFY = 5'b10000;

    reg [4:0] state_q;
    reg chip_op_q;
    reg last_frame_q;
    reg verify_bad_q;
    reg [23:0] end_q;
    reg tmr_start;
    reg [23:0] tmr_load;
    wire tmr_busy;
    wire tmr_done;
    wire sck_level;
    wire sck_rise;

    // The link clock is only counted; frames arrive already parsed
    edge_sync u_sck_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .d(link_sck),
        .level(sck_level),
        .rise(sck_rise)
    );

    // One timer serves every operation, as only one runs at a time
    op_timer u_timer (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(tmr_start),
        .load(tmr_load),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Counts rising link clock edges for frame activity visibility
    always @(posedge ref_clk) begin
        if (reset) begin
            sck_edges <= 8'h00;
        end else if (sck_rise && sck_level) begin
            sck_edges <= sck_edges + 8'h01;
        end
    end

    wire is_status = (frame_cmd == `CMD_STATUS);
    // Anything but a status request during an operation is refused
    wire stray = frame_valid && (frame_is_data || !is_status);

    // Each command has one fixed frame size; other lengths are malformed
    wire frame_bad = !etx_ok ||
        ((frame_cmd == `CMD_BLOCK_ERASE || frame_cmd == `CMD_PROGRAM) &&
         frame_length_field != `LEN_RANGE) ||
        ((frame_cmd == `CMD_CHIP_ERASE || is_status) && frame_length_field != `LEN_SHORT);
    wire start_aligned = (start_addr_bytes[`BLOCK_BITS-1:0] == 10'h000);
    wire end_aligned = (end_addr_bytes[`BLOCK_BITS-1:0] == 10'h3FF);
    wire range_ok = start_aligned && end_aligned && (end_addr_bytes >= start_addr_bytes);
    // A range starting inside the boot area is taken to touch it
    wire hits_boot = prot_boot && (start_addr_bytes <= boot_end_addr);
    // Block count in range, used to scale the modelled erase time
    wire [13:0] blk_count = end_addr_bytes[23:10] - start_addr_bytes[23:10] + 14'h0001;
    wire [37:0] blk_time = erase_cycles * blk_count;

    // Busy also spans the gaps between data frames of a programming run
    assign flash_busy = (state_q != S_IDLE);

    always @(posedge ref_clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            chip_op_q <= 1'b0;
            last_frame_q <= 1'b0;
            verify_bad_q <= 1'b0;
            end_q <= 24'h00_0000;
            first_status_byte <= `ST_ACK;
            second_status_byte <= `ST_ACK;
            status_update <= 1'b0;
            tmr_start <= 1'b0;
            tmr_load <= 24'h00_0000;
        end else begin
            status_update <= 1'b0;
            tmr_start <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    // Status requests are served by the link layer
                    if (frame_valid && !frame_is_data && !is_status) begin
                        status_update <= 1'b1;
                        second_status_byte <= `ST_ACK;
                        if (!csum_ok) begin
                            first_status_byte <= `ST_CSUM_ERR; // R7
                        end else if (frame_bad) begin
                            first_status_byte <= `ST_NACK; // R8
                        end else if (frame_cmd == `CMD_CHIP_ERASE) begin
                            if (prot_chip_erase && prot_boot) begin
                                first_status_byte <= `ST_PROTECT_ERR; // R10
                            end else begin
                                first_status_byte <= `ST_BUSY;
                                chip_op_q <= 1'b1;
                                tmr_load <= erase_cycles;
                                tmr_start <= 1'b1;
                                state_q <= S_ERASE;
                            end
                        end else if (frame_cmd == `CMD_BLOCK_ERASE) begin
                            if (prot_write || prot_block_erase || prot_chip_erase ||
                                hits_boot) begin
                                first_status_byte <= `ST_PROTECT_ERR; // R11
                            end else if (!range_ok) begin
                                first_status_byte <= `ST_PARAM_ERR; // R12
                            end else begin
                                // Whole range is one timed operation; ack only at its end
                                first_status_byte <= `ST_BUSY; // R6
                                chip_op_q <= 1'b0;
                                tmr_load <= (blk_time[37:24] != 14'h0000) ?
                                    24'hFF_FFFF : blk_time[23:0];
                                tmr_start <= 1'b1;
                                state_q <= S_ERASE;
                            end
                        end else if (frame_cmd == `CMD_PROGRAM) begin
                            if (prot_write || hits_boot) begin
                                first_status_byte <= `ST_PROTECT_ERR;
                            end else if (!range_ok) begin
                                first_status_byte <= `ST_PARAM_ERR; // R23
                            end else begin
                                first_status_byte <= `ST_ACK;
                                verify_bad_q <= 1'b0;
                                last_frame_q <= 1'b0;
                                end_q <= end_addr_bytes;
                                state_q <= S_DATA;
                            end
                        end else begin
                            first_status_byte <= `ST_NACK;
                        end
                    end
                end

                S_ERASE: begin
                    if (stray) begin
                        // Rejected without disturbing the running erase
                        first_status_byte <= `ST_NACK; // R9
                        status_update <= 1'b1;
                    end
                    if (tmr_done) begin
                        status_update <= 1'b1;
                        state_q <= S_IDLE;
                        // Fault inputs count only as the operation ends
                        if (internal_fault_a) begin
                            first_status_byte <= `ST_FAULT_A; // R13
                        end else if (chip_op_q && internal_fault_b) begin
                            first_status_byte <= `ST_FAULT_B; // R13
                        end else if (chip_op_q && write_fault) begin
                            first_status_byte <= `ST_WRITE_ERR; // R13
                        end else begin
                            first_status_byte <= `ST_ACK; // R5
                        end
                    end
                end

                S_DATA: begin
                    // A bad frame here abandons the whole programming run
                    if (frame_valid) begin
                        status_update <= 1'b1;
                        if (!frame_is_data) begin
                            if (!is_status) begin
                                first_status_byte <= `ST_NACK;
                                state_q <= S_IDLE;
                            end
                        end else if (!csum_ok) begin
                            first_status_byte <= `ST_CSUM_ERR;
                            state_q <= S_IDLE;
                        // Empty or oversized payloads count as malformed
                        end else if (!etx_ok || data_count == 9'h000 ||
                                     data_count > `MAX_DATA_LEN) begin
                            first_status_byte <= `ST_NACK;
                            state_q <= S_IDLE;
                        end else begin
                            first_status_byte <= `ST_ACK;
                            second_status_byte <= `ST_BUSY;
                            last_frame_q <= data_end;
                            tmr_load <= write_cycles;
                            tmr_start <= 1'b1;
                            state_q <= S_WRITE;
                        end
                    end
                end

                S_WRITE: begin
                    if (stray) begin
                        first_status_byte <= `ST_NACK;
                        status_update <= 1'b1;
                    end
                    if (tmr_done) begin
                        status_update <= 1'b1;
                        if (write_fault) begin
                            second_status_byte <= `ST_WRITE_ERR;
                            state_q <= S_IDLE;
                        end else begin
                            second_status_byte <= `ST_ACK;
                            // Held so one bad frame fails the final status
                            verify_bad_q <= verify_bad_q | verify_fault;
                            if (last_frame_q) begin
                                // Verify time is four write times plus the end block number
                                first_status_byte <= `ST_BUSY; // R21
                                tmr_load <= (write_cycles << 2) + {10'h000, end_q[23:10]};
                                tmr_start <= 1'b1;
                                state_q <= S_VERIFY;
                            end else begin
                                state_q <= S_DATA;
                            end
                        end
                    end
                end

                S_VERIFY: begin
                    if (stray) begin
                        first_status_byte <= `ST_NACK;
                        status_update <= 1'b1;
                    end
                    if (tmr_done) begin
                        status_update <= 1'b1;
                        state_q <= S_IDLE;
                        if (verify_bad_q || verify_fault) begin
                            first_status_byte <= `ST_FAULT_B; // R24
                        end else begin
                            first_status_byte <= `ST_ACK; // R21
                        end
                    end
                end

                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // flash_cmd_engine
`default_nettype wire

// >>> logic/op_timer.v
// Purpose: Down counter that models the duration of an internal flash operation
// Assumes: start is a one-cycle pulse; load is a cycle count
// Notes: done pulses for one cycle when the count runs out
`timescale 1ns/1ps
`default_nettype none
module op_timer (
    input wire ref_clk,
    input wire reset,
    input wire start,
    input wire [23:0] load,
    output wire busy,
    output reg done
);
    reg [23:0] cnt_q;
    always @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= 24'h00_0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= (load == 24'h00_0000) ? 24'h00_0001 : load;
            end else if (cnt_q != 24'h00_0000) begin
                cnt_q <= cnt_q - 24'h00_0001;
                if (cnt_q == 24'h00_0001) begin
                    done <= 1'b1;
                end
            end
        end
    end
    assign busy = (cnt_q != 24'h00_0000);
endmodule // op_timer
`default_nettype wire

// >>> tb/flash_cmd_sva.sv
// Purpose: Port-level checks of the flash command interpreter
// Assumes: One clock domain, synchronous active-high reset
// Notes: Completion codes of timed operations are judged by the bench
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"
module flash_cmd_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_valid,
    input wire logic frame_is_data,
    input wire logic [7:0] frame_cmd,
    input wire logic [7:0] frame_length_field,
    input wire logic [23:0] start_addr_bytes,
    input wire logic [23:0] end_addr_bytes,
    input wire logic csum_ok,
    input wire logic etx_ok,
    input wire logic prot_write,
    input wire logic prot_block_erase,
    input wire logic prot_chip_erase,
    input wire logic prot_boot,
    input wire logic [7:0] first_status_byte,
    input wire logic status_update,
    input wire logic flash_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic cmd_in = frame_valid && !frame_is_data && frame_cmd != `CMD_STATUS;
    wire logic clean = cmd_in && csum_ok && etx_ok && !flash_busy;
    wire logic chip = clean && frame_cmd == `CMD_CHIP_ERASE && frame_length_field == `LEN_SHORT;
    wire logic aligned = start_addr_bytes[9:0] == 10'h000 && end_addr_bytes[9:0] == 10'h3FF;
    wire logic locked = prot_write || prot_block_erase || prot_chip_erase;
    wire logic sized = frame_length_field == `LEN_RANGE;
    a_csum_reply: assert property (cmd_in && !csum_ok && !flash_busy |=>
        status_update && first_status_byte == `ST_CSUM_ERR) else $error("checksum reply wrong");
    a_frame_nack: assert property (cmd_in && csum_ok && !etx_ok && !flash_busy |=>
        status_update && first_status_byte == `ST_NACK) else $error("bad frame not refused");
    a_length_nack: assert property (clean && frame_cmd == `CMD_CHIP_ERASE &&
        frame_length_field != `LEN_SHORT |=> first_status_byte == `ST_NACK)
        else $error("bad length not refused");
    a_busy_nack: assert property (cmd_in && csum_ok && etx_ok && flash_busy |=>
        status_update && first_status_byte == `ST_NACK) else $error("command taken while busy");
    a_chip_start: assert property (chip && !(prot_chip_erase && prot_boot) |=>
        status_update && first_status_byte == `ST_BUSY && flash_busy)
        else $error("chip erase did not start");
    a_chip_lock: assert property (chip && prot_chip_erase && prot_boot |=>
        first_status_byte == `ST_PROTECT_ERR) else $error("locked chip erase not refused");
    a_block_lock: assert property (clean && sized && frame_cmd == `CMD_BLOCK_ERASE &&
        aligned && locked |=> first_status_byte == `ST_PROTECT_ERR)
        else $error("locked block erase not refused");
    a_range_param: assert property (clean && !aligned && !locked && !prot_boot &&
        sized && (frame_cmd == `CMD_BLOCK_ERASE || frame_cmd == `CMD_PROGRAM)
        |=> first_status_byte == `ST_PARAM_ERR) else $error("unaligned range not refused");
    a_done_update: assert property ($fell(flash_busy) |-> ##[0:2] status_update)
        else $error("operation ended without status");
    c_ack_idle: cover property (status_update && first_status_byte == `ST_ACK && !flash_busy);
    c_busy_cmd: cover property (cmd_in && flash_busy);
    c_fault: cover property (status_update && first_status_byte == `ST_FAULT_A);
endmodule // flash_cmd_sva
bind flash_cmd_engine flash_cmd_sva i_flash_cmd_sva (.ref_clk(ref_clk), .reset(reset),
    .frame_valid(frame_valid), .frame_is_data(frame_is_data), .frame_cmd(frame_cmd),
    .frame_length_field(frame_length_field), .start_addr_bytes(start_addr_bytes),
    .end_addr_bytes(end_addr_bytes), .csum_ok(csum_ok), .etx_ok(etx_ok),
    .prot_write(prot_write), .prot_block_erase(prot_block_erase),
    .prot_chip_erase(prot_chip_erase), .prot_boot(prot_boot),
    .first_status_byte(first_status_byte), .status_update(status_update),
    .flash_busy(flash_busy));
`default_nettype wire

// >>> tb/prog_model.sv
// Purpose: Behavioural programmer presenting decoded frames and link clock bursts
// Assumes: Driven just after the falling edge of ref_clk
// Notes: Link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module prog_model #(parameter int GAP = 4) (
    input wire logic ref_clk,
    output logic link_sck,
    output logic frame_valid,
    output logic frame_is_data,
    output logic [7:0] frame_cmd,
    output logic [7:0] frame_length_field,
    output logic [23:0] start_addr_bytes,
    output logic [23:0] end_addr_bytes,
    output logic [8:0] data_count,
    output logic data_end,
    output logic csum_ok,
    output logic etx_ok
);
    logic [7:0] edges = 8'h00;
    initial begin
        {link_sck, frame_valid, frame_is_data, frame_cmd, frame_length_field} = '0;
        {start_addr_bytes, end_addr_bytes, data_count, data_end, csum_ok, etx_ok} = '0;
    end
    task automatic send(input logic d, input logic [7:0] cmd, input logic [7:0] len,
        input logic [23:0] sa, input logic [23:0] ea, input logic [8:0] cnt, input logic last,
        input logic [1:0] chk);
        repeat (GAP) @(negedge ref_clk);
        repeat (2) begin
            #200 link_sck = 1'b1;
            edges = edges + 8'h01;
            #200 link_sck = 1'b0;
        end
        @(negedge ref_clk);
        {frame_is_data, frame_cmd, frame_length_field, start_addr_bytes} = {d, cmd, len, sa};
        {end_addr_bytes, data_count, data_end, csum_ok, etx_ok} = {ea, cnt, last, chk};
        frame_valid = 1'b1;
        @(negedge ref_clk);
        frame_valid = 1'b0;
        // Released fields change so a late sample cannot pass by luck
        {frame_cmd, start_addr_bytes, end_addr_bytes} =
            ~{frame_cmd, start_addr_bytes, end_addr_bytes};
    endtask
endmodule // prog_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench of the flash command interpreter
// Assumes: Short erase and write counts set at the instance
// Notes: Random refusals plus hand-written erase and programming flows
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic link_sck, frame_valid, frame_is_data, data_end, csum_ok, etx_ok;
    logic status_update, flash_busy;
    logic [7:0] frame_cmd, frame_length_field, first_status_byte, second_status_byte, sck_edges;
    logic [23:0] start_addr_bytes, end_addr_bytes, sa, ea;
    logic [8:0] data_count;
    logic [3:0] prot = 4'h0;
    logic [3:0] fault = 4'h0;
    logic [7:0] cmd, code;
    int mismatches = 0;
    int n_compared = 0;
    int unsigned kind, sblk;
    always #25 ref_clk = ~ref_clk;
    prog_model i_prog_model (.ref_clk(ref_clk), .link_sck(link_sck), .frame_valid(frame_valid),
        .frame_is_data(frame_is_data), .frame_cmd(frame_cmd),
        .frame_length_field(frame_length_field),
        .start_addr_bytes(start_addr_bytes), .end_addr_bytes(end_addr_bytes),
        .data_count(data_count), .data_end(data_end), .csum_ok(csum_ok), .etx_ok(etx_ok));
    flash_cmd_engine i_flash_cmd_engine (.ref_clk(ref_clk), .reset(reset), .link_sck(link_sck),
        .frame_valid(frame_valid), .frame_is_data(frame_is_data), .frame_cmd(frame_cmd),
        .frame_length_field(frame_length_field), .start_addr_bytes(start_addr_bytes),
        .end_addr_bytes(end_addr_bytes), .data_count(data_count), .data_end(data_end),
        .csum_ok(csum_ok), .etx_ok(etx_ok), .prot_write(prot[0]), .prot_block_erase(prot[1]),
        .prot_chip_erase(prot[2]), .prot_boot(prot[3]), .boot_end_addr(24'h00_0FFF),
        .internal_fault_a(fault[0]), .internal_fault_b(fault[1]), .write_fault(fault[2]),
        .verify_fault(fault[3]), .erase_cycles(24'h00_0040), .write_cycles(24'h00_0010),
        .first_status_byte(first_status_byte), .second_status_byte(second_status_byte),
        .status_update(status_update), .flash_busy(flash_busy), .sck_edges(sck_edges));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Busy codes are skipped; only a final code in the chosen byte ends the wait
    task automatic wait_code(input bit second, output logic [7:0] got);
        for (int i = 0; i < 4000; i++) begin
            got = second ? second_status_byte : first_status_byte;
            if (status_update === 1'b1 && got !== `ST_BUSY) return;
            @(negedge ref_clk);
        end
        // A run-out wait fails whatever the last byte held
        $display("unexpected at %0t: no final status, seen %h expected %h", $time, got, 8'h00);
        mismatches++;
        print_verdict();
    endtask
    function automatic logic [7:0] expect_code(int unsigned k);
        case (k)
            0: return `ST_CSUM_ERR;
            1: return `ST_NACK;
            2: return `ST_PARAM_ERR;
            default: return `ST_PROTECT_ERR;
        endcase
    endfunction
    initial begin
        void'($urandom(32'h7ca1));
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        check(first_status_byte, `ST_ACK);
        check({second_status_byte[6:0], flash_busy}, 8'h0C);
        for (int n = 0; n < 16; n++) begin
            kind = $urandom % 4;
            sblk = $urandom % 256;
            sa = 24'(sblk) << 10;
            ea = (24'(sblk + $urandom % (256 - sblk)) << 10) | 24'h00_03FF;
            cmd = (n % 2) ? ((kind == 2) ? `CMD_PROGRAM : `CMD_CHIP_ERASE) : `CMD_BLOCK_ERASE;
            if (kind == 2) sa = sa + 24'(1 + $urandom % 1023);
            if (kind == 3) prot = (cmd == `CMD_CHIP_ERASE) ? 4'hC : 4'h1 << ($urandom % 4);
            if (prot[3]) sa = 24'h00_0000;
            i_prog_model.send(1'b0, cmd, (cmd == `CMD_CHIP_ERASE) ? `LEN_SHORT : `LEN_RANGE,
                sa, ea, 9'h000, 1'b0, (kind == 0) ? 2'b01 : (kind == 1) ? 2'b10 : 2'b11);
            wait_code(0, code);
            check(code, expect_code(kind));
            prot = 4'h0;
        end
        i_prog_model.send(1'b0, `CMD_CHIP_ERASE, `LEN_RANGE, 0, 0, 0, 0, 2'b11);
        wait_code(0, code);
        check(code, `ST_NACK);
        $display("test refusals done");
        i_prog_model.send(1'b0, `CMD_CHIP_ERASE, `LEN_SHORT, 0, 0, 0, 0, 2'b11);
        repeat (2) @(negedge ref_clk);
        check({first_status_byte[6:0], flash_busy}, 8'hFF);
        i_prog_model.send(1'b0, `CMD_BLOCK_ERASE, `LEN_RANGE, 24'h00_0400, 24'h00_07FF,
            0, 0, 2'b11);
        wait_code(0, code);
        check(code, `ST_NACK);
        @(negedge ref_clk);
        wait_code(0, code);
        check(code, `ST_ACK);
        for (int f = 0; f < 3; f++) begin
            fault = 4'h1 << f;
            i_prog_model.send(1'b0, `CMD_CHIP_ERASE, `LEN_SHORT, 0, 0, 0, 0, 2'b11);
            wait_code(0, code);
            check(code, `ST_FAULT_A + 8'(f));
        end
        for (int b = 0; b < 2; b++) begin
            fault = 4'(b);
            sa = 24'($urandom % 250) << 10;
            i_prog_model.send(1'b0, `CMD_BLOCK_ERASE, `LEN_RANGE, sa,
                sa + (24'($urandom % 3) << 10) + 24'h00_03FF, 0, 0, 2'b11);
            wait_code(0, code);
            check(code, b ? `ST_FAULT_A : `ST_ACK);
        end
        fault = 4'h0;
        $display("test erase done");
        for (int p = 0; p < 3; p++) begin
            fault = (p == 1) ? 4'h8 : 4'h0;
            i_prog_model.send(1'b0, `CMD_PROGRAM, `LEN_RANGE, 24'h00_0400, 24'h00_0BFF,
                0, 0, 2'b11);
            wait_code(0, code);
            check(code, `ST_ACK);
            for (int f = 0; f < 8; f++) begin
                if (p == 2 && f == 1) fault = 4'h4;
                i_prog_model.send(1'b1, 8'h00, 8'h00, 0, 0, `MAX_DATA_LEN, f == 7,
                    2'b11);
                wait_code(1, code);
                check(code, fault[2] ? `ST_WRITE_ERR : `ST_ACK);
                if (code !== `ST_ACK) break;
            end
            if (p != 2) begin
                @(negedge ref_clk);
                wait_code(0, code);
                check(code, p ? `ST_FAULT_B : `ST_ACK);
            end
            fault = 4'h0;
        end
        $display("test programming done");
        repeat (4) @(negedge ref_clk);
        check(sck_edges, i_prog_model.edges);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
